// file: gp_timer_pkg.sv
/*
 * shared constants and types for the paired general-purpose timer.
 * assumes an APB bus with 32-bit data and byte addressing.
 */
package gp_timer_pkg;
	// ----------------------------------------------------------------
	// register word indices; each byte address is four times its index
	// ----------------------------------------------------------------
	localparam int ADDR_IDX_SHIFT = 2;
	localparam logic [11:0] IDX_LOW_COUNT = 12'h106;
	localparam logic [11:0] IDX_HOLDING = 12'h108;
	localparam logic [11:0] IDX_HIGH_COUNT = 12'h10a;
	localparam logic [11:0] IDX_LOW_PERIOD = 12'h10c;
	localparam logic [11:0] IDX_HIGH_PERIOD = 12'h10e;
	localparam logic [11:0] IDX_LOW_CTRL = 12'h110;
	localparam logic [11:0] IDX_HIGH_CTRL = 12'h112;
	localparam logic [11:0] IDX_IRQ = 12'h114;
	// odd indices would break word alignment, so the bus sees index * 4
	localparam logic [11:0] ADDR_LOW_COUNT = IDX_LOW_COUNT << ADDR_IDX_SHIFT;
	localparam logic [11:0] ADDR_HOLDING = IDX_HOLDING << ADDR_IDX_SHIFT;
	localparam logic [11:0] ADDR_HIGH_COUNT = IDX_HIGH_COUNT << ADDR_IDX_SHIFT;
	localparam logic [11:0] ADDR_LOW_PERIOD = IDX_LOW_PERIOD << ADDR_IDX_SHIFT;
	localparam logic [11:0] ADDR_HIGH_PERIOD = IDX_HIGH_PERIOD << ADDR_IDX_SHIFT;
	localparam logic [11:0] ADDR_LOW_CTRL = IDX_LOW_CTRL << ADDR_IDX_SHIFT;
	localparam logic [11:0] ADDR_HIGH_CTRL = IDX_HIGH_CTRL << ADDR_IDX_SHIFT;
	localparam logic [11:0] ADDR_IRQ = IDX_IRQ << ADDR_IDX_SHIFT;

	// ----------------------------------------------------------------
	// reset values and control fields
	// ----------------------------------------------------------------
	localparam logic [15:0] PERIOD_RESET = 16'hffff;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] CTRL_MASK = 16'ha07a;
	localparam int BIT_RUN = 15;
	localparam int BIT_IDLE_HALT = 13;
	localparam int BIT_GATE = 6;
	localparam int BIT_PRE_HI = 5;
	localparam int BIT_PRE_LO = 4;
	localparam int BIT_PAIR = 3;
	localparam int BIT_SRC = 1;
	localparam int BIT_IRQ_FLAG = 7;
	localparam int BIT_IRQ_EN = 7;
	localparam int BIT_LOW_FLAG = 6;
	localparam int BIT_LOW_EN = 6;
	localparam int IRQ_EN_OFS = 8;
	localparam logic [7:0] PRE_MAX_1 = 8'h00;
	localparam logic [7:0] PRE_MAX_8 = 8'h07;
	localparam logic [7:0] PRE_MAX_64 = 8'h3f;
	localparam logic [7:0] PRE_MAX_256 = 8'hff;

	typedef struct packed {
		logic run;
		logic idle_halt;
		logic gate;
		logic [1:0] prescale;
		logic pair;
		logic ext_src;
	} timer_ctrl_t;
endpackage

// file: paired_gp_timer.sv
/*
 * paired 16-bit general-purpose timers, optionally joined into one 32-bit
 * timer or synchronous counter, with an APB register slave.
 * assumes the external clock/gate pin and the idle/sleep inputs are
 * synchronous to pclk.
 */
`timescale 1ns/10ps

// Function
// - paired, first timer is low word, second timer is high word.
// - paired, first control register rules; second timer's flag and enable used.
// - unpaired, each timer independent, internal timer, gated timer or synchronous counter.
// - only first timer resynchronises its prescaler output.
// - paired timer counts each cycle to combined period, then wraps to zero.
// - reading low count latches high count into holding register.
// - paired, low count write loads high count from holding register together.
// - paired counter counts external rising edges, wraps at combined period.
// - idle halts the count when halt-in-idle set; resumes after idle.
// - gated mode counts cycles only while gate pin high.
// - paired gated mode uses first timer; second gate bit ignored.
// - gate falling edge stops counting, count kept.
// - combined period match pulses the ADC trigger.
// - prescaler divides by 1, 8, 64 or 256 from bits 5:4.
// - paired mode ignores the second timer's prescaler.
// - count writes, run-bit clear or reset clear the prescaler.
// - a disabled timer's prescaler is cleared by neither high count writes nor low count writes.
// - control writes leave counts unchanged.
// - no counting during sleep.
// - paired match or gate fall sets flag bit 7; enable gates request.
// - unpaired timer counts each cycle to own period, then wraps.
module paired_gp_timer #(
	parameter int CNT_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_pin_low,
	input wire logic ext_pin_high,
	input wire logic cpu_idle,
	input wire logic cpu_sleep,
	output logic adc_trigger,
	output logic irq_low,
	output logic irq_pair
);
	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic gp_timer_pkg::timer_ctrl_t unpack_ctrl(input logic [15:0] r);
		gp_timer_pkg::timer_ctrl_t c;
		c.run = r[gp_timer_pkg::BIT_RUN];
		c.idle_halt = r[gp_timer_pkg::BIT_IDLE_HALT];
		c.gate = r[gp_timer_pkg::BIT_GATE];
		c.prescale = r[gp_timer_pkg::BIT_PRE_HI:gp_timer_pkg::BIT_PRE_LO];
		c.pair = r[gp_timer_pkg::BIT_PAIR];
		c.ext_src = r[gp_timer_pkg::BIT_SRC];
		return c;
	endfunction

	function automatic logic [7:0] pre_max(input logic [1:0] sel);
		case (sel)
			2'h0: pre_max = gp_timer_pkg::PRE_MAX_1;
			2'h1: pre_max = gp_timer_pkg::PRE_MAX_8;
			2'h2: pre_max = gp_timer_pkg::PRE_MAX_64;
			default: pre_max = gp_timer_pkg::PRE_MAX_256;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] count_q [2];
	logic [CNT_W-1:0] period_q [2];
	logic [15:0] ctrl_q [2];
	logic [CNT_W-1:0] holding_q;
	logic [7:0] pre_q [2];
	logic [1:0] pin_q;
	logic tick_sync_q;
	logic flag_low_q, flag_pair_q, en_low_q, en_pair_q;
	gp_timer_pkg::timer_ctrl_t cfg [2];
	logic paired;

	assign cfg[0] = unpack_ctrl(ctrl_q[0]);
	assign cfg[1] = unpack_ctrl(ctrl_q[1]);
	assign paired = cfg[0].pair;

	// apb access strobes
	logic acc, wr, rd;
	assign acc = psel && penable && clk_en;
	assign wr = acc && pwrite;
	// reads sample in the setup cycle, so low word and holding word see one edge
	assign rd = psel && !penable && !pwrite && clk_en;
	logic wr_cnt [2];
	logic wr_ctrl [2];
	assign wr_cnt[0] = wr && paddr == gp_timer_pkg::ADDR_LOW_COUNT;
	assign wr_cnt[1] = wr && paddr == gp_timer_pkg::ADDR_HIGH_COUNT;
	assign wr_ctrl[0] = wr && paddr == gp_timer_pkg::ADDR_LOW_CTRL;
	assign wr_ctrl[1] = wr && paddr == gp_timer_pkg::ADDR_HIGH_CTRL;

	// ----------------------------------------------------------------
	// prescalers and count enables
	// ----------------------------------------------------------------
	// in pair mode the second timer shares the first's setup
	logic src_tick [2];
	logic pre_tick [2];
	logic run_ok [2];
	logic gate_fall;
	logic [1:0] pin_now;
	assign pin_now = {ext_pin_high, ext_pin_low};
	assign gate_fall = pin_q[0] && !ext_pin_low && cfg[0].run && cfg[0].gate && !cfg[0].ext_src;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_tmr
			gp_timer_pkg::timer_ctrl_t c;
			logic clr_pre;
			assign c = cfg[gi];
			// sleep, and idle with idle_halt set, freeze the clock tree of the timer
			assign run_ok[gi] = c.run && !cpu_sleep && !(cpu_idle && c.idle_halt);
			// pin sample of own input; counter mode sees rising edges only
			assign src_tick[gi] = c.ext_src ? (pin_now[gi] && !pin_q[gi])
				: (c.gate ? pin_now[gi] : 1'b1);
			assign pre_tick[gi] = run_ok[gi] && src_tick[gi] && pre_q[gi] == pre_max(c.prescale);
			// low or high count writes clear a running timer's prescaler; a stopped timer's prescaler is not cleared by either
			assign clr_pre = c.run && wr_cnt[0] | wr_cnt[1];
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pre_q[gi] <= 8'h00;
				end else if (clk_en) begin
					if (wr_ctrl[gi] && c.run && !pwdata[gp_timer_pkg::BIT_RUN]) begin
						pre_q[gi] <= 8'h00;
					end else if (clr_pre) begin
						pre_q[gi] <= 8'h00;
					end else if (run_ok[gi] && src_tick[gi]) begin
						pre_q[gi] <= pre_tick[gi] ? 8'h00 : pre_q[gi] + 8'h01;
					end
				end
			end
		end
	endgenerate

	// pin history and first-timer resync stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_q <= 2'h0;
			tick_sync_q <= 1'b0;
		end else if (clk_en) begin
			pin_q <= pin_now;
			tick_sync_q <= pre_tick[0];
		end
	end

	// first timer ticks one cycle late through its resync flop; costs latency
	logic tick_low, tick_high;
	assign tick_low = tick_sync_q && run_ok[0];
	assign tick_high = paired ? 1'b0 : pre_tick[1];

	// ----------------------------------------------------------------
	// counters
	// ----------------------------------------------------------------
	logic match_low, match_high, match_pair;
	assign match_low = count_q[0] == period_q[0];
	assign match_high = count_q[1] == period_q[1];
	assign match_pair = paired && tick_low && match_low && match_high;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q[0] <= '0;
			count_q[1] <= '0;
		end else if (clk_en) begin
			if (wr_cnt[0]) begin
				count_q[0] <= pwdata[CNT_W-1:0];
				if (paired) begin
					count_q[1] <= holding_q;
				end
			end else if (paired && tick_low) begin
				// low word carries into high word
				if (match_pair) begin
					count_q[0] <= '0;
					count_q[1] <= '0;
				end else if (&count_q[0]) begin
					count_q[0] <= '0;
					count_q[1] <= count_q[1] + 1'b1;
				end else begin
					count_q[0] <= count_q[0] + 1'b1;
				end
			end else if (!paired && tick_low) begin
				count_q[0] <= match_low ? '0 : count_q[0] + 1'b1;
			end
			if (wr_cnt[1]) begin
				count_q[1] <= pwdata[CNT_W-1:0];
			end else if (tick_high) begin
				count_q[1] <= match_high ? '0 : count_q[1] + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// config registers and holding word
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_q[0] <= gp_timer_pkg::PERIOD_RESET;
			period_q[1] <= gp_timer_pkg::PERIOD_RESET;
			ctrl_q[0] <= gp_timer_pkg::CTRL_RESET;
			ctrl_q[1] <= gp_timer_pkg::CTRL_RESET;
		end else if (clk_en && wr) begin
			case (paddr)
				gp_timer_pkg::ADDR_LOW_PERIOD: period_q[0] <= pwdata[CNT_W-1:0];
				gp_timer_pkg::ADDR_HIGH_PERIOD: period_q[1] <= pwdata[CNT_W-1:0];
				gp_timer_pkg::ADDR_LOW_CTRL: ctrl_q[0] <= pwdata[15:0] & gp_timer_pkg::CTRL_MASK;
				gp_timer_pkg::ADDR_HIGH_CTRL: ctrl_q[1] <= pwdata[15:0] & gp_timer_pkg::CTRL_MASK;
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			holding_q <= '0;
		end else if (clk_en) begin
			if (wr && paddr == gp_timer_pkg::ADDR_HOLDING) begin
				holding_q <= pwdata[CNT_W-1:0];
			end else if (rd && paddr == gp_timer_pkg::ADDR_LOW_COUNT) begin
				holding_q <= count_q[1];
			end
		end
	end

	// ----------------------------------------------------------------
	// event flags: hardware set wins over software clear
	// ----------------------------------------------------------------
	logic set_pair, set_low, wr_irq;
	assign set_pair = match_pair || (paired && gate_fall) || (!paired && tick_high && match_high);
	assign set_low = !paired && ((tick_low && match_low) || gate_fall);
	assign wr_irq = wr && paddr == gp_timer_pkg::ADDR_IRQ;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_low_q <= 1'b0;
			flag_pair_q <= 1'b0;
			en_low_q <= 1'b0;
			en_pair_q <= 1'b0;
		end else if (clk_en) begin
			// writing zero clears a flag, writing one leaves it
			flag_pair_q <= set_pair | (flag_pair_q & ~(wr_irq & ~pwdata[gp_timer_pkg::BIT_IRQ_FLAG]));
			flag_low_q <= set_low | (flag_low_q & ~(wr_irq & ~pwdata[gp_timer_pkg::BIT_LOW_FLAG]));
			if (wr_irq) begin
				en_pair_q <= pwdata[gp_timer_pkg::IRQ_EN_OFS + gp_timer_pkg::BIT_IRQ_EN];
				en_low_q <= pwdata[gp_timer_pkg::IRQ_EN_OFS + gp_timer_pkg::BIT_LOW_EN];
			end
		end
	end

	// ----------------------------------------------------------------
	// registered outputs and apb read path
	// ----------------------------------------------------------------
	logic [31:0] rd_d;
	always_comb begin
		rd_d = 32'h0;
		case (paddr)
			gp_timer_pkg::ADDR_LOW_COUNT: rd_d[CNT_W-1:0] = count_q[0];
			gp_timer_pkg::ADDR_HOLDING: rd_d[CNT_W-1:0] = holding_q;
			gp_timer_pkg::ADDR_HIGH_COUNT: rd_d[CNT_W-1:0] = count_q[1];
			gp_timer_pkg::ADDR_LOW_PERIOD: rd_d[CNT_W-1:0] = period_q[0];
			gp_timer_pkg::ADDR_HIGH_PERIOD: rd_d[CNT_W-1:0] = period_q[1];
			gp_timer_pkg::ADDR_LOW_CTRL: rd_d[15:0] = ctrl_q[0];
			gp_timer_pkg::ADDR_HIGH_CTRL: rd_d[15:0] = ctrl_q[1];
			gp_timer_pkg::ADDR_IRQ: begin
				rd_d[gp_timer_pkg::BIT_IRQ_FLAG] = flag_pair_q;
				rd_d[gp_timer_pkg::BIT_LOW_FLAG] = flag_low_q;
				rd_d[gp_timer_pkg::IRQ_EN_OFS + gp_timer_pkg::BIT_IRQ_EN] = en_pair_q;
				rd_d[gp_timer_pkg::IRQ_EN_OFS + gp_timer_pkg::BIT_LOW_EN] = en_low_q;
			end
			default: rd_d = 32'h0;
		endcase
	end

	logic mapped;
	assign mapped = paddr inside {gp_timer_pkg::ADDR_LOW_COUNT, gp_timer_pkg::ADDR_HOLDING,
		gp_timer_pkg::ADDR_HIGH_COUNT, gp_timer_pkg::ADDR_LOW_PERIOD, gp_timer_pkg::ADDR_HIGH_PERIOD,
		gp_timer_pkg::ADDR_LOW_CTRL, gp_timer_pkg::ADDR_HIGH_CTRL, gp_timer_pkg::ADDR_IRQ};

	// zero-wait slave: pready is a flop raised in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else if (clk_en) begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= rd ? rd_d : 32'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adc_trigger <= 1'b0;
			irq_low <= 1'b0;
			irq_pair <= 1'b0;
		end else if (clk_en) begin
			adc_trigger <= match_pair;
			irq_pair <= flag_pair_q && en_pair_q;
			irq_low <= flag_low_q && en_low_q;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_pair_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && match_pair && !wr_cnt[0] |=> count_q[0] == '0 && count_q[1] == '0)
		else $error("paired count did not wrap on match");
	chk_hold_latch: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && rd && paddr == gp_timer_pkg::ADDR_LOW_COUNT |=> holding_q == $past(count_q[1])
		&& prdata[CNT_W-1:0] == $past(count_q[0]))
		else $error("holding register missed high word");
	chk_hold_load: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && wr_cnt[0] && paired |=> count_q[1] == $past(holding_q))
		else $error("high word not loaded from holding");
	chk_adc_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && match_pair |=> adc_trigger)
		else $error("no adc trigger on match");
	chk_sleep_hold: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && cpu_sleep && !wr_cnt[0] && !wr_cnt[1] && $past(cpu_sleep) |=> $stable(count_q[0]))
		else $error("count moved in sleep");
	chk_ctrl_keep: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && wr_ctrl[0] && !tick_low |=> count_q[0] == $past(count_q[0]))
		else $error("control write changed count");
	chk_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && set_pair |=> flag_pair_q ##1 (irq_pair || !en_pair_q))
		else $error("pair flag or request missing");
	chk_pre_clear: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && cfg[0].run && wr_cnt[0] |=> pre_q[0] == 8'h00)
		else $error("prescaler not cleared on count write");
	chk_second_idle: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && paired && !wr_cnt[1] && !tick_low && !wr_cnt[0] |=> $stable(count_q[1]))
		else $error("high word moved without low carry");
endmodule

// file: ext_pin_model.sv
/*
 * model of the external clock / gate pins of the paired timer.
 * assumes the bench clock drives it and the bench calls its tasks.
 */
`timescale 1ns/10ps
module ext_pin_model (
	input wire logic pclk,
	output logic pin_low,
	output logic pin_high
);
	// ----------------------------------------------------------------
	// pin drive
	// ----------------------------------------------------------------
	// pins are fitted here, so counter and gated modes are legal
	// idle level low: the external clock stands still between bursts
	initial begin
		pin_low = 1'b0;
		pin_high = 1'b0;
	end
	// n rising edges, three cycles high so the resync flops catch each one
	task automatic pulses(input logic sel, input int n);
		repeat (n) begin
			@(posedge pclk);
			pin_high <= sel;
			pin_low <= !sel;
			repeat (3) @(posedge pclk);
			pin_high <= 1'b0;
			pin_low <= 1'b0;
			repeat (2) @(posedge pclk);
		end
	endtask
	// gate held high for n cycles, then dropped
	task automatic gate(input int n);
		@(posedge pclk);
		pin_low <= 1'b1;
		repeat (n) @(posedge pclk);
		pin_low <= 1'b0;
	endtask
endmodule

// file: tb_top.sv
/*
 * self-checking bench for the paired timer: apb master tasks, scenarios.
 * assumes the pin model beside the design; apb waits end on pready or the watchdog.
 */
`timescale 1ns/10ps
module tb_top;
	localparam logic [11:0] A_LC = gp_timer_pkg::ADDR_LOW_COUNT;
	localparam logic [11:0] A_HD = gp_timer_pkg::ADDR_HOLDING;
	localparam logic [11:0] A_HC = gp_timer_pkg::ADDR_HIGH_COUNT;
	localparam logic [11:0] A_LP = gp_timer_pkg::ADDR_LOW_PERIOD;
	localparam logic [11:0] A_HP = gp_timer_pkg::ADDR_HIGH_PERIOD;
	localparam logic [11:0] A_LK = gp_timer_pkg::ADDR_LOW_CTRL;
	localparam logic [11:0] A_HK = gp_timer_pkg::ADDR_HIGH_CTRL;
	localparam logic [11:0] A_IQ = gp_timer_pkg::ADDR_IRQ;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cpu_idle, cpu_sleep;
	logic adc_trigger, irq_low, irq_pair, ext_lo, ext_hi, err_q;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_q, v1_q;
	int err_count, checks_done, adc_seen;
	paired_gp_timer dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_pin_low(ext_lo), .ext_pin_high(ext_hi), .cpu_idle(cpu_idle),
		.cpu_sleep(cpu_sleep), .adc_trigger(adc_trigger), .irq_low(irq_low), .irq_pair(irq_pair));
	ext_pin_model pin (.pclk(pclk), .pin_low(ext_lo), .pin_high(ext_hi));
	// ----------------------------------------------------------------
	// clock, trigger monitor, watchdog
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// trigger is a one-cycle pulse, so count it at every edge
	always @(posedge pclk) if (adc_trigger === 1'b1) adc_seen++;
	// about 6k cycles of tests; generous margin
	initial begin
		#400000;
		err_count++;
		conclude();
	end
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic in_range(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
		check({31'h0, (v >= lo && v <= hi)}, 32'h1);
	endtask
	// request held until pready is sampled high; answer taken at that edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no wait count is assumed; a slave that never answers is left to the watchdog
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a);
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic conclude();
		$display("errors %0d, checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rd(A_LP);
		check(rd_q, 32'h0000ffff);
		rd(A_HP);
		check(rd_q, 32'h0000ffff);
		rd(A_LK);
		check(rd_q, 32'h0);
		rd(A_HK);
		check(rd_q, 32'h0);
		rd(12'h200);
		check({31'h0, err_q}, 32'h1);
		// stopped timer: control write keeps the count, masked bits read back
		wr(A_LC, 32'h1234);
		wr(A_LK, 32'h5f75);
		rd(A_LK);
		check(rd_q, 32'h0070);
		rd(A_LC);
		check(rd_q, 32'h1234);
		wr(A_LK, 32'h0);
	endtask
	// every prescale code on both timers at once, then a wrap at a low period of 5
	task automatic t_prescale();
		for (int c = 0; c < 4; c++) begin
			wr(A_LC, 32'h0);
			wr(A_HC, 32'h0);
			wr(A_LK, 32'h8000 | (c << 4));
			wr(A_HK, 32'h8000 | (c << 4));
			repeat (1024) @(posedge pclk);
			wr(A_LK, 32'h0);
			wr(A_HK, 32'h0);
			v1_q = 32'd1024 >> ((c == 0) ? 0 : (c == 1) ? 3 : (c == 2) ? 6 : 8);
			rd(A_LC);
			in_range(rd_q, v1_q - 1, v1_q + 8);
			rd(A_HC);
			in_range(rd_q, v1_q - 1, v1_q + 8);
		end
		wr(A_LP, 32'h5);
		wr(A_LC, 32'h0);
		wr(A_LK, 32'h8000);
		repeat (50) @(posedge pclk);
		wr(A_LK, 32'h0);
		rd(A_LC);
		in_range(rd_q, 0, 5);
		// the wraps above raised the low flag; enable it, then clear it
		rd(A_IQ);
		check({31'h0, rd_q[6]}, 32'h1);
		wr(A_IQ, 32'h4040);
		repeat (2) @(posedge pclk);
		check({31'h0, irq_low}, 32'h1);
		wr(A_IQ, 32'h0);
		repeat (2) @(posedge pclk);
		check({31'h0, irq_low}, 32'h0);
		wr(A_LP, 32'hffff);
	endtask
	// 32-bit run across the word carry and through one combined match
	task automatic t_pair();
		wr(A_LP, 32'h0005);
		wr(A_HP, 32'h0002);
		wr(A_LK, 32'h0008);
		wr(A_HK, 32'h8030);
		wr(A_IQ, 32'h0);
		wr(A_HD, 32'h0001);
		wr(A_LC, 32'hfff0);
		rd(A_HC);
		check(rd_q, 32'h0001);
		rd(A_LC);
		check(rd_q, 32'hfff0);
		rd(A_HD);
		check(rd_q, 32'h0001);
		adc_seen = 0;
		wr(A_LK, 32'h8008);
		repeat (40) @(posedge pclk);
		wr(A_LK, 32'h0008);
		check(adc_seen, 32'h1);
		rd(A_LC);
		in_range(rd_q, 12, 28);
		rd(A_HD);
		check(rd_q, 32'h0);
		rd(A_IQ);
		check({31'h0, rd_q[7]}, 32'h1);
		check({31'h0, irq_pair}, 32'h0);
		wr(A_IQ, 32'h8080);
		repeat (2) @(posedge pclk);
		check({31'h0, irq_pair}, 32'h1);
		wr(A_IQ, 32'h8000);
		repeat (2) @(posedge pclk);
		check({31'h0, irq_pair}, 32'h0);
		wr(A_IQ, 32'h0);
		wr(A_LP, 32'hffff);
		wr(A_HP, 32'hffff);
	endtask
	// paired gated accumulation; second gate bit set but ignored
	task automatic t_gate();
		wr(A_HD, 32'h0);
		wr(A_LC, 32'h0);
		wr(A_HK, 32'h0040);
		wr(A_LK, 32'h8048);
		pin.gate(100);
		repeat (5) @(posedge pclk);
		rd(A_LC);
		v1_q = rd_q;
		in_range(v1_q, 96, 102);
		repeat (50) @(posedge pclk);
		rd(A_LC);
		check(rd_q, v1_q);
		rd(A_IQ);
		check({31'h0, rd_q[7]}, 32'h1);
		wr(A_LK, 32'h0);
		wr(A_HK, 32'h0);
		wr(A_IQ, 32'h0);
	endtask
	// external clock: paired on the first pin, then second timer alone
	task automatic t_ext();
		wr(A_LC, 32'h0);
		wr(A_LK, 32'h800a);
		pin.pulses(1'b0, 10);
		repeat (8) @(posedge pclk);
		wr(A_LK, 32'h0);
		rd(A_LC);
		check(rd_q, 32'd10);
		rd(A_HD);
		check(rd_q, 32'h0);
		wr(A_HC, 32'h0);
		wr(A_HK, 32'h8002);
		pin.pulses(1'b1, 7);
		repeat (8) @(posedge pclk);
		wr(A_HK, 32'h0);
		rd(A_HC);
		check(rd_q, 32'd7);
	endtask
	// idle with and without the halt bit, and sleep
	task automatic t_idle();
		for (int k = 0; k < 3; k++) begin
			wr(A_LC, 32'h0);
			wr(A_LK, (k == 2) ? 32'h8000 : 32'ha000);
			cpu_idle <= (k != 1);
			cpu_sleep <= (k == 1);
			repeat (3) @(posedge pclk);
			rd(A_LC);
			v1_q = rd_q;
			repeat (20) @(posedge pclk);
			rd(A_LC);
			if (k == 2) in_range(rd_q, v1_q + 18, v1_q + 30);
			else check(rd_q, v1_q);
			// halted cases have not moved; the free-running case rebases here
			v1_q = rd_q;
			cpu_idle <= 1'b0;
			cpu_sleep <= 1'b0;
			repeat (20) @(posedge pclk);
			rd(A_LC);
			in_range(rd_q, v1_q + 18, v1_q + 30);
			wr(A_LK, 32'h0);
		end
	endtask
	// count writes every 200 cycles keep a 1:256 prescaler from ever ticking
	task automatic t_preclear();
		wr(A_LC, 32'h0);
		wr(A_LK, 32'h8030);
		repeat (4) begin
			repeat (200) @(posedge pclk);
			wr(A_LC, 32'h0);
		end
		rd(A_LC);
		check(rd_q, 32'h0);
		wr(A_LK, 32'h0);
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		cpu_idle = 1'b0;
		cpu_sleep = 1'b0;
		err_count = 0;
		checks_done = 0;
		adc_seen = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_prescale();
		t_pair();
		t_gate();
		t_ext();
		t_idle();
		t_preclear();
		conclude();
	end
endmodule
